// ===== shared/iss_pkg.sv
package iss_pkg;

    // command opcodes delivered by the bus command parser
    typedef enum logic [4:0] {
        OP_NONE = 5'h00,
        OP_OPC = 5'h01,
        OP_OPC_Q = 5'h02,
        OP_RST = 5'h03,
        OP_TST_Q = 5'h04,
        OP_SRE = 5'h05,
        OP_SRE_Q = 5'h06,
        OP_ESE = 5'h07,
        OP_ESE_Q = 5'h08,
        OP_ESR_Q = 5'h09,
        OP_STB_Q = 5'h0a,
        OP_COND_Q = 5'h0b,
        OP_PTR = 5'h0c,
        OP_PTR_Q = 5'h0d,
        OP_NTR = 5'h0e,
        OP_NTR_Q = 5'h0f,
        OP_EVENT_Q = 5'h10,
        OP_OPER_EN = 5'h11,
        OP_OPER_EN_Q = 5'h12,
        OP_ERR_Q = 5'h13,
        OP_ERR_MODE = 5'h14,
        OP_KEY = 5'h15,
        OP_KEY_Q = 5'h16,
        OP_FMT = 5'h17,
        OP_FMT_Q = 5'h18,
        OP_TRG = 5'h19,
        OP_GET = 5'h1a,
        OP_TRIG_SRC = 5'h1b,
        OP_TRIG_SRC_Q = 5'h1c,
        OP_WAI = 5'h1d
    } iss_op_t;

    // sequencer states, gray along idle -> wait -> idle except idle -> tst wait -> idle (00 -> 11 -> 00)
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_OPC_WAIT = 2'b01,
        ST_TST_WAIT = 2'b11,
        ST_WAI_WAIT = 2'b10
    } iss_state_t;

    typedef struct packed {
        logic valid;
        iss_op_t op;
        logic [7:0] arg;
    } iss_cmd_t;

    typedef struct packed {
        logic valid;
        logic text;
        logic [7:0] data;
    } iss_resp_t;

    // status byte bit positions
    localparam int STB_MAV = 4;
    localparam int STB_ESB = 5;
    localparam int STB_MSS = 6;
    localparam int STB_OSB = 7;
    // standard event register operation-complete bit
    localparam int ESR_OPC = 0;
    // first valid key code, and the key code that presets
    localparam logic [7:0] KEY_FIRST = 8'h01;
    localparam logic [7:0] KEY_PRESET = 8'h14;
    // reset values, then the fixed answers one and zero
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [7:0] PTR_RST = 8'hff;
    localparam logic [7:0] NTR_RST = 8'h00;
    localparam logic [7:0] KEY_RST = 8'h00;
    localparam logic ERR_TEXT_RST = 1'b1;
    localparam logic FMT_FP64_RST = 1'b0;
    localparam logic TRIG_BUS_RST = 1'b0;
    localparam logic [7:0] ANS_ONE = 8'h01;
    localparam logic [7:0] ANS_ZERO = 8'h00;

endpackage

// ===== hdl/iss_status_trigger.sv
// Operation
// - opc command sets esr opc bit once nothing is pending
// - opc query answers 1 only after pending work finishes
// - enabled opc bit can raise a service request
// - reset command presets panel state, keeps status and results
// - self-test query runs test, answers 0 pass, 1 fail
// - status byte: bit4 message, bit5 esr summary, bit7 operation summary
// - service request mask is stored and read back
// - standard event mask is stored as 8 bits, read 0..255
// - esr query returns contents and clears the register
// - status byte query returns byte with master summary in bit 6
// - summary bits clear only through their underlying structure
// - operation events latch on filtered rising or falling conditions
// - condition and event queries return present register values
// - operation enable mask selects events into status bit 7
// - transition filter queries return stored masks
// - error query returns code, numeric or text, text by default
// - key command simulates keys 1..20, query gives last key
// - result format is ascii text or 64-bit float
// - trigger or group trigger starts measurement only in bus mode
// - free-run starts back to back, bus mode waits for trigger
// - wait command holds off further commands until work finishes
`timescale 1ns/1ps
module iss_status_trigger
    import iss_pkg::*;
#(
    parameter int KEY_LAST = 20,
    parameter int OPER_W = 8
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire iss_cmd_t cmd,
    input wire logic pending,
    input wire logic meas_busy,
    input wire logic msg_avail,
    input wire logic [OPER_W-1:0] oper_cond,
    input wire logic [7:1] esr_evt,
    input wire logic err_evt,
    input wire logic [7:0] err_code,
    input wire logic test_done,
    input wire logic test_fail,
    output logic cmd_ready,
    output iss_resp_t resp,
    output logic srq,
    output logic meas_start,
    output logic test_start,
    output logic preset,
    output logic key_valid,
    output logic [7:0] key_code,
    output logic fmt_fp64,
    output logic trig_bus,
    output logic err_text
);

    // the logic is written for an 8-bit operation structure and 8-bit keycodes,
    // so other widths are refused while the design is elaborated
    if (OPER_W != 8 || KEY_LAST < 1 || KEY_LAST > 255) begin : g_param_check
        $error("iss_status_trigger: unsupported parameter values");
    end

    localparam logic [7:0] KEY_LAST_C = 8'(KEY_LAST);

    iss_state_t state, next_state;
    logic next_cmd_ready;
    iss_resp_t next_resp;
    logic next_meas_start, next_test_start, next_preset, next_key_valid;
    logic [7:0] next_key_code;
    logic next_fmt_fp64, next_trig_bus, next_err_text;

    logic [7:0] esr, next_esr;
    logic [7:0] ese, next_ese;
    logic [7:0] sre, next_sre;
    logic [7:0] ptr, next_ptr;
    logic [7:0] ntr, next_ntr;
    logic [7:0] oper_en, next_oper_en;
    logic [7:0] oper_ev, next_oper_ev;
    logic [7:0] cond_q, next_cond_q;
    logic [7:0] err_reg, next_err_reg;
    logic opc_armed, next_opc_armed;
    logic next_srq;
    logic meas_armed, next_meas_armed;

    logic take;
    logic [7:0] stb_bits;
    logic mss;
    logic esr_clr, ev_clr, err_clr;

    // a command is taken only while the sequencer is idle
    assign take = cmd.valid && cmd_ready;

    // summary byte built from the live structures; mss computed apart
    always_comb begin
        stb_bits = 8'h00;
        stb_bits[STB_MAV] = msg_avail;
        stb_bits[STB_ESB] = |(esr & ese);
        stb_bits[STB_OSB] = |(oper_ev & oper_en);
        // master summary, bit 6 of the mask never counts
        mss = |(stb_bits & sre & ~(8'h01 << STB_MSS));
    end

    // command sequencer and control settings
    always_comb begin
        next_state = state;
        next_resp = '0;
        next_meas_start = 1'b0;
        next_test_start = 1'b0;
        next_preset = 1'b0;
        next_key_valid = 1'b0;
        next_key_code = key_code;
        next_fmt_fp64 = fmt_fp64;
        next_trig_bus = trig_bus;
        next_err_text = err_text;
        next_meas_armed = meas_armed;
        esr_clr = 1'b0;
        ev_clr = 1'b0;
        err_clr = 1'b0;
        case (state)
            ST_IDLE: begin
                if (take) begin
                    next_resp.valid = 1'b1;
                    case (cmd.op)
                        OP_OPC_Q: begin
                            // answer held back while work is pending
                            next_resp.valid = 1'b0;
                            next_state = ST_OPC_WAIT;
                        end
                        OP_TST_Q: begin
                            next_resp.valid = 1'b0;
                            next_test_start = 1'b1;
                            next_state = ST_TST_WAIT;
                        end
                        OP_WAI: begin
                            next_resp.valid = 1'b0;
                            next_state = ST_WAI_WAIT;
                        end
                        OP_RST: begin
                            next_resp.valid = 1'b0;
                            next_preset = 1'b1;
                            next_trig_bus = TRIG_BUS_RST;
                        end
                        OP_SRE_Q: next_resp.data = sre;
                        OP_ESE_Q: next_resp.data = ese;
                        OP_ESR_Q: begin
                            next_resp.data = esr;
                            esr_clr = 1'b1;
                        end
                        OP_STB_Q: begin
                            next_resp.data = stb_bits | (8'(mss) << STB_MSS);
                        end
                        OP_COND_Q: next_resp.data = cond_q;
                        OP_EVENT_Q: begin
                            // present event value, then cleared by the read
                            next_resp.data = oper_ev;
                            ev_clr = 1'b1;
                        end
                        OP_PTR_Q: next_resp.data = ptr;
                        OP_NTR_Q: next_resp.data = ntr;
                        OP_OPER_EN_Q: next_resp.data = oper_en;
                        OP_ERR_Q: begin
                            // code plus form flag for the formatter
                            next_resp.data = err_reg;
                            next_resp.text = err_text;
                            err_clr = 1'b1;
                        end
                        OP_ERR_MODE: begin
                            next_resp.valid = 1'b0;
                            next_err_text = cmd.arg[0];
                        end
                        OP_KEY: begin
                            next_resp.valid = 1'b0;
                            // only codes 1..20 count as presses
                            if (cmd.arg >= KEY_FIRST && cmd.arg <= KEY_LAST_C) begin
                                next_key_valid = 1'b1;
                                next_key_code = cmd.arg;
                                if (cmd.arg == KEY_PRESET) begin
                                    next_preset = 1'b1;
                                    next_trig_bus = TRIG_BUS_RST;
                                end
                            end
                        end
                        OP_KEY_Q: next_resp.data = key_code;
                        OP_FMT: begin
                            // one bit: ascii or 64-bit float
                            next_resp.valid = 1'b0;
                            next_fmt_fp64 = cmd.arg[0];
                        end
                        OP_FMT_Q: next_resp.data = {7'h00, fmt_fp64};
                        OP_TRG, OP_GET: begin
                            next_resp.valid = 1'b0;
                            if (trig_bus) begin
                                next_meas_armed = 1'b1;
                            end
                        end
                        OP_TRIG_SRC: begin
                            next_resp.valid = 1'b0;
                            next_trig_bus = cmd.arg[0];
                            next_meas_armed = 1'b0;
                        end
                        OP_TRIG_SRC_Q: next_resp.data = {7'h00, trig_bus};
                        default: next_resp.valid = 1'b0;
                    endcase
                end
            end
            ST_OPC_WAIT: begin
                // fixed answer of 1 once idle
                if (!pending) begin
                    next_resp.valid = 1'b1;
                    next_resp.data = ANS_ONE;
                    next_state = ST_IDLE;
                end
            end
            ST_TST_WAIT: begin
                if (test_done) begin
                    next_resp.valid = 1'b1;
                    next_resp.data = test_fail ? ANS_ONE : ANS_ZERO;
                    next_state = ST_IDLE;
                end
            end
            ST_WAI_WAIT: begin
                if (!pending) begin
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
        // start pulse: armed trigger in bus mode, any idle slot in free-run
        // the start is suppressed while the previous pulse is in flight
        if (!meas_busy && !meas_start && (!next_trig_bus || meas_armed)) begin
            next_meas_start = 1'b1;
            if (next_trig_bus) begin
                next_meas_armed = 1'b0;
            end
        end
        // ready drops the cycle after a stalling command is taken
        next_cmd_ready = (next_state == ST_IDLE);
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state <= ST_IDLE;
            cmd_ready <= 1'b0;
            resp <= '0;
            meas_start <= 1'b0;
            test_start <= 1'b0;
            preset <= 1'b0;
            key_valid <= 1'b0;
            key_code <= KEY_RST;
            fmt_fp64 <= FMT_FP64_RST;
            trig_bus <= TRIG_BUS_RST;
            err_text <= ERR_TEXT_RST;
            meas_armed <= 1'b0;
        end else if (ce) begin
            state <= next_state;
            cmd_ready <= next_cmd_ready;
            resp <= next_resp;
            meas_start <= next_meas_start;
            test_start <= next_test_start;
            preset <= next_preset;
            key_valid <= next_key_valid;
            key_code <= next_key_code;
            fmt_fp64 <= next_fmt_fp64;
            trig_bus <= next_trig_bus;
            err_text <= next_err_text;
            meas_armed <= next_meas_armed;
        end
    end

    // status structures; a new event always wins over a read-clear
    always_comb begin
        next_ese = ese;
        next_sre = sre;
        next_ptr = ptr;
        next_ntr = ntr;
        next_oper_en = oper_en;
        next_opc_armed = opc_armed;
        next_cond_q = oper_cond;
        next_err_reg = err_clr ? 8'h00 : err_reg;
        if (err_evt) begin
            next_err_reg = err_code;
        end
        if (take) begin
            case (cmd.op)
                OP_SRE: next_sre = cmd.arg;
                OP_ESE: next_ese = cmd.arg;
                OP_PTR: next_ptr = cmd.arg;
                OP_NTR: next_ntr = cmd.arg;
                OP_OPER_EN: next_oper_en = cmd.arg;
                OP_OPC: next_opc_armed = 1'b1;
                default: next_opc_armed = opc_armed;
            endcase
        end
        // clear on read, summaries follow the register
        next_esr = esr_clr ? 8'h00 : esr;
        next_esr[7:1] = next_esr[7:1] | esr_evt;
        // opc bit set once nothing is pending
        // with ese bit 0 and sre bit 5 set this reaches srq
        if (opc_armed && !pending) begin
            next_esr[ESR_OPC] = 1'b1;
            next_opc_armed = 1'b0;
        end
        // filtered edge capture into the event register
        next_oper_ev = ev_clr ? 8'h00 : oper_ev;
        next_oper_ev = next_oper_ev | (ptr & oper_cond & ~cond_q)
            | (ntr & ~oper_cond & cond_q);
        next_srq = mss;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            esr <= MASK_RST;
            ese <= MASK_RST;
            sre <= MASK_RST;
            ptr <= PTR_RST;
            ntr <= NTR_RST;
            oper_en <= MASK_RST;
            oper_ev <= MASK_RST;
            cond_q <= MASK_RST;
            err_reg <= MASK_RST;
            opc_armed <= 1'b0;
            srq <= 1'b0;
        end else if (ce) begin
            esr <= next_esr;
            ese <= next_ese;
            sre <= next_sre;
            ptr <= next_ptr;
            ntr <= next_ntr;
            oper_en <= next_oper_en;
            oper_ev <= next_oper_ev;
            cond_q <= next_cond_q;
            err_reg <= next_err_reg;
            opc_armed <= next_opc_armed;
            srq <= next_srq;
        end
    end

endmodule

// ===== bench/iss_props.sv
`timescale 1ns/1ps
module iss_props
    import iss_pkg::*;
#(
    parameter int KEY_LAST = 20,
    parameter int OPER_W = 8
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire iss_cmd_t cmd,
    input wire logic pending,
    input wire logic meas_busy,
    input wire logic msg_avail,
    input wire logic [OPER_W-1:0] oper_cond,
    input wire logic [7:1] esr_evt,
    input wire logic err_evt,
    input wire logic [7:0] err_code,
    input wire logic test_done,
    input wire logic test_fail,
    input wire logic cmd_ready,
    input wire iss_resp_t resp,
    input wire logic srq,
    input wire logic meas_start,
    input wire logic test_start,
    input wire logic preset,
    input wire logic key_valid,
    input wire logic [7:0] key_code,
    input wire logic fmt_fp64,
    input wire logic trig_bus,
    input wire logic err_text
);
    // a command counts only on an enabled edge with ready high
    wire logic take = ce && cmd.valid && cmd_ready;
    wire logic key_ok = cmd.arg inside {[KEY_FIRST:KEY_LAST]};

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // plain queries answer on the next edge
    a_query_answer: assert property (take && cmd.op inside {OP_SRE_Q, OP_ESE_Q,
        OP_ESR_Q, OP_STB_Q, OP_COND_Q, OP_EVENT_Q} |=> resp.valid)
        else $error("query gave no answer");
    a_stb_layout: assert property (take && cmd.op == OP_STB_Q |=>
        resp.data[STB_MSS] == srq && resp.data[3:0] == 4'h0)
        else $error("status byte layout wrong");
    a_wai_stall: assert property (take && cmd.op == OP_WAI |=> !cmd_ready)
        else $error("wait did not stall");
    // held off for as long as work is pending
    a_wai_hold: assert property (!cmd_ready && pending |=> !cmd_ready)
        else $error("ready while work pending");
    a_tst_launch: assert property (take && cmd.op == OP_TST_Q |=> test_start && !cmd_ready)
        else $error("self-test not launched");
    a_tst_verdict: assert property (test_done && !cmd_ready |=>
        resp.valid && resp.data == {7'h00, $past(test_fail)})
        else $error("self-test answer wrong");
    a_key_accept: assert property (take && cmd.op == OP_KEY && key_ok |=>
        key_valid && key_code == $past(cmd.arg))
        else $error("key press lost");
    a_key_refuse: assert property (take && cmd.op == OP_KEY && !key_ok |=> !key_valid)
        else $error("bad key code accepted");
    a_preset_pulse: assert property (take && (cmd.op == OP_RST ||
        (cmd.op == OP_KEY && cmd.arg == KEY_PRESET)) |=> preset)
        else $error("preset missing");
    a_fmt_pick: assert property (take && cmd.op == OP_FMT |=> fmt_fp64 == $past(cmd.arg[0]))
        else $error("format not taken");
    // free-run restarts within two cycles of the engine going idle
    a_free_run: assert property ((ce && !trig_bus && !meas_busy)[*2] |-> ##[0:1] meas_start)
        else $error("free-run stalled");

    c_wai: cover property (take && cmd.op == OP_WAI);
    c_tst: cover property (test_done && !cmd_ready);
    c_preset: cover property (preset);
endmodule

bind iss_status_trigger iss_props #(.KEY_LAST(KEY_LAST), .OPER_W(OPER_W)) u_props (
    .mclk(mclk), .rst(rst), .ce(ce), .cmd(cmd), .pending(pending), .meas_busy(meas_busy),
    .msg_avail(msg_avail), .oper_cond(oper_cond), .esr_evt(esr_evt), .err_evt(err_evt),
    .err_code(err_code), .test_done(test_done), .test_fail(test_fail), .cmd_ready(cmd_ready),
    .resp(resp), .srq(srq), .meas_start(meas_start), .test_start(test_start), .preset(preset),
    .key_valid(key_valid), .key_code(key_code), .fmt_fp64(fmt_fp64), .trig_bus(trig_bus),
    .err_text(err_text));

// ===== bench/iss_back_end.sv
`timescale 1ns/1ps
module iss_back_end
    import iss_pkg::*;
#(
    parameter int MEAS_CYC = 6,
    parameter int TEST_CYC = 9
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic meas_start,
    input wire logic test_start,
    input wire logic fail_sel,
    output logic meas_busy,
    output logic test_done,
    output logic test_fail
);
    int mcnt;
    int tcnt;

    // busy per start
    // a fixed busy span keeps free-run restarts countable
    always_ff @(posedge mclk) begin
        if (rst) begin
            mcnt <= 0;
        end else if (meas_start) begin
            mcnt <= MEAS_CYC;
        end else if (mcnt > 0) begin
            mcnt <= mcnt - 1;
        end
    end
    assign meas_busy = (mcnt > 0);

    always_ff @(posedge mclk) begin
        if (rst) begin
            tcnt <= 0;
        end else if (test_start) begin
            tcnt <= TEST_CYC;
        end else if (tcnt > 0) begin
            tcnt <= tcnt - 1;
        end
    end
    assign test_done = (tcnt == 1);
    // outside the done pulse the verdict is inverted, so late sampling shows
    assign test_fail = test_done ? fail_sel : ~fail_sel;
endmodule

// ===== bench/iss_status_trigger_bench.sv
`timescale 1ns/1ps
module iss_status_trigger_bench
    import iss_pkg::*;
;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    iss_cmd_t cmd = '0;
    logic pending = 1'b0;
    logic msg_avail = 1'b0;
    logic err_evt = 1'b0;
    logic fail_sel = 1'b0;
    logic [7:0] oper_cond = 8'h00;
    logic [7:1] esr_evt = 7'h00;
    logic [7:0] err_code = 8'h00;
    logic cmd_ready, srq, meas_start, test_start, preset, key_valid, fmt_fp64, trig_bus, err_text;
    logic meas_busy, test_done, test_fail, rt;
    logic [7:0] key_code, rd;
    iss_resp_t resp;
    int fail_count = 0;
    int checks = 0;
    int starts = 0;
    int s0;
    iss_op_t wo[5] = '{OP_SRE, OP_ESE, OP_OPER_EN, OP_PTR, OP_NTR};
    iss_op_t rq[7] = '{OP_SRE_Q, OP_ESE_Q, OP_OPER_EN_Q, OP_PTR_Q, OP_NTR_Q, OP_KEY_Q, OP_FMT_Q};
    logic [7:0] rv[7] = '{MASK_RST, MASK_RST, MASK_RST, PTR_RST, NTR_RST, KEY_RST, 8'h00};
    logic [7:0] wv[5] = '{8'hff, 8'ha5, 8'h3c, 8'h0f, 8'hf0};
    logic [7:0] kc[6] = '{8'h00, 8'h15, 8'h01, 8'h10, 8'h12, 8'h14};
    logic [7:0] ke[6] = '{8'h05, 8'h05, 8'h01, 8'h10, 8'h12, 8'h14};

    iss_status_trigger dut (.mclk(mclk), .rst(rst), .ce(ce), .cmd(cmd), .pending(pending),
        .meas_busy(meas_busy), .msg_avail(msg_avail), .oper_cond(oper_cond), .esr_evt(esr_evt),
        .err_evt(err_evt), .err_code(err_code), .test_done(test_done), .test_fail(test_fail),
        .cmd_ready(cmd_ready), .resp(resp), .srq(srq), .meas_start(meas_start),
        .test_start(test_start), .preset(preset), .key_valid(key_valid), .key_code(key_code),
        .fmt_fp64(fmt_fp64), .trig_bus(trig_bus), .err_text(err_text));
    iss_back_end eng (.mclk(mclk), .rst(rst), .meas_start(meas_start), .test_start(test_start),
        .fail_sel(fail_sel), .meas_busy(meas_busy), .test_done(test_done), .test_fail(test_fail));

    // 25 MHz clock and a running count of measurement starts
    always #20 mclk = ~mclk;
    always @(posedge mclk) if (meas_start === 1'b1) starts <= starts + 1;

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // hold the command until an edge sees ready, then leave one idle cycle
    task automatic send(input iss_op_t op, input logic [7:0] arg);
        int n;
        n = 0;
        cmd <= '{1'b1, op, arg};
        @(posedge mclk);
        while (cmd_ready !== 1'b1) begin
            n++;
            if (n > 300) begin
                fail_count++;
                give_verdict();
            end
            @(posedge mclk);
        end
        cmd <= '0;
        @(posedge mclk);
    endtask

    // answers stand one cycle, so poll every edge with a bound
    task automatic get_resp();
        int n;
        n = 0;
        while (resp.valid !== 1'b1) begin
            n++;
            if (n > 300) begin
                fail_count++;
                give_verdict();
            end
            @(posedge mclk);
        end
        rd = resp.data;
        rt = resp.text;
    endtask

    task automatic ask(input iss_op_t op, input logic [7:0] exp);
        send(op, 8'h00);
        get_resp();
        check(rd, exp);
    endtask

    initial begin
        tick(6);
        rst <= 1'b0;
        tick(2);
        for (int i = 0; i < 7; i++) begin
            ask(rq[i], rv[i]);
        end
        check(err_text, 8'h01);
        for (int i = 0; i < 5; i++) begin
            send(wo[i], wv[i]);
            ask(rq[i], wv[i]);
        end
        $display("test masks done");
        // standard event bit 5 through to the service request
        esr_evt <= 7'h10;
        tick(1);
        esr_evt <= 7'h00;
        tick(2);
        check(srq, 8'h01);
        ask(OP_STB_Q, 8'h60);
        ask(OP_ESR_Q, 8'h20);
        ask(OP_ESR_Q, 8'h00);
        ask(OP_STB_Q, 8'h00);
        check(srq, 8'h00);
        msg_avail <= 1'b1;
        tick(2);
        ask(OP_STB_Q, 8'h50);
        msg_avail <= 1'b0;
        $display("test status done");
        oper_cond <= 8'hff;
        tick(3);
        ask(OP_STB_Q, 8'hc0);
        ask(OP_COND_Q, 8'hff);
        ask(OP_EVENT_Q, 8'h0f);
        ask(OP_EVENT_Q, 8'h00);
        oper_cond <= 8'h00;
        tick(3);
        ask(OP_EVENT_Q, 8'hf0);
        $display("test operation done");
        pending <= 1'b1;
        send(OP_OPC, 8'h00);
        tick(4);
        ask(OP_ESR_Q, 8'h00);
        check(srq, 8'h00);
        pending <= 1'b0;
        tick(3);
        check(srq, 8'h01);
        ask(OP_ESR_Q, 8'h01);
        pending <= 1'b1;
        send(OP_OPC_Q, 8'h00);
        tick(5);
        check(resp.valid, 8'h00);
        pending <= 1'b0;
        get_resp();
        check(rd, ANS_ONE);
        $display("test completion done");
        // a key press queued behind a wait must not land early
        pending <= 1'b1;
        send(OP_WAI, 8'h00);
        cmd <= '{1'b1, OP_KEY, 8'h05};
        tick(4);
        check(key_code, KEY_RST);
        pending <= 1'b0;
        send(OP_KEY, 8'h05);
        send(OP_TRIG_SRC, 8'h01);
        for (int i = 0; i < 6; i++) begin
            send(OP_KEY, kc[i]);
            ask(OP_KEY_Q, ke[i]);
        end
        check(trig_bus, 8'h00);
        send(OP_TRIG_SRC, 8'h01);
        esr_evt <= 7'h40;
        tick(1);
        esr_evt <= 7'h00;
        send(OP_RST, 8'h00);
        check(trig_bus, 8'h00);
        ask(OP_SRE_Q, 8'hff);
        ask(OP_ESR_Q, 8'h80);
        $display("test keys done");
        send(OP_FMT, 8'h01);
        check(fmt_fp64, 8'h01);
        ask(OP_FMT_Q, 8'h01);
        send(OP_FMT, 8'h00);
        check(fmt_fp64, 8'h00);
        // with the clock enable low a presented command must leave no trace
        ce <= 1'b0;
        send(OP_FMT, 8'h01);
        check(fmt_fp64, 8'h00);
        ce <= 1'b1;
        err_code <= 8'h2a;
        err_evt <= 1'b1;
        tick(1);
        err_evt <= 1'b0;
        ask(OP_ERR_Q, 8'h2a);
        check(rt, 8'h01);
        send(OP_ERR_MODE, 8'h00);
        ask(OP_ERR_Q, 8'h00);
        check(rt, 8'h00);
        $display("test format done");
        send(OP_TRIG_SRC, 8'h01);
        tick(12);
        s0 = starts;
        tick(20);
        check(8'(starts - s0), 8'h00);
        send(OP_TRG, 8'h00);
        tick(12);
        check(8'(starts - s0), 8'h01);
        send(OP_GET, 8'h00);
        tick(12);
        check(8'(starts - s0), 8'h02);
        send(OP_TRIG_SRC, 8'h00);
        tick(24);
        check(8'(starts - s0 > 4), 8'h01);
        $display("test trigger done");
        fail_sel <= 1'b0;
        ask(OP_TST_Q, ANS_ZERO);
        fail_sel <= 1'b1;
        ask(OP_TST_Q, ANS_ONE);
        rst <= 1'b1;
        tick(6);
        rst <= 1'b0;
        tick(2);
        ask(OP_SRE_Q, MASK_RST);
        $display("test selftest done");
        give_verdict();
    end
endmodule
